// [hw/wit_top.sv]
// watchdog and interval timer with wishbone register access
// ***********************************
// Overview of operation
// - 32-bit up counter, reachable only through the control register.
// - clock-select field picks subsystem, auxiliary, low-power or extra clock.
// - interval field picks one of eight counter expiry points.
// - after power-up-clear: watchdog mode, subsystem clock, about 32 ms.
// - control write with wrong key in upper byte forces power-up-clear.
// - control word reads always show 69h in upper byte.
// - byte reads of either half return the low byte.
// - any byte write to the control register forces power-up-clear.
// - watchdog expiry forces power-up-clear, restoring default configuration.
// - mode bit 1 selects interval mode, 0 watchdog mode.
// - interval expiry sets the timer flag, no reset, enable untouched.
// - interrupt only while flag, enable and global enable are set.
// - flag clears when serviced, or by software.
// - interval interrupt is distinct from the reset path.
// - flag is bit 0 of flag register, enable bit 0 of enable register.
// - flag set after own reset, clear after other reset causes.
// - in watchdog mode the selected clock is kept running.
// - failed subsystem or auxiliary clock falls back to low-power oscillator.
// - interval mode has no clock fallback.
// - hold bit freezes the counter; clearing it resumes.
// ***********************************
`timescale 1ns/1ps
`default_nettype none
module wit_top
    import wit_pkg::*;
#(
    parameter int CNT_W = WIT_CNT_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIT_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [3:0] clk_tick_i,
    input wire logic sub_clk_fail_i,
    input wire logic aux_clk_fail_i,
    input wire logic global_irq_enable_i,
    input wire logic irq_serviced_i,
    input wire logic other_puc_i,
    output logic power_up_clear_reset_o,
    output logic interval_irq_o,
    output logic [3:0] clk_keep_on_o
);

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        wit_ctrl_type ctrl;
        logic timer_flag;
        logic timer_irq_enable;
        logic ack;
        logic [31:0] dat;
        logic power_up_clear_reset;
        logic irq;
        logic [3:0] keep;
    } wit_state_type;

    localparam wit_state_type WIT_STATE_RST = '{
        ctrl: WIT_CTRL_RST, timer_flag: 1'b0, timer_irq_enable: 1'b0, ack: 1'b0,
        dat: 32'h0, power_up_clear_reset: 1'b0, irq: 1'b0, keep: 4'h1};

    wit_state_type st_ff;
    wit_state_type nxt_st;

    // ***********************************
    // helpers
    // ***********************************
    function automatic logic [1:0] eff_src(input wit_ctrl_type c, input logic sub_fail, input logic aux_fail);
        logic [1:0] r;
        r = c.ssel;
        // interval mode keeps the chosen source even if dead
        if (!c.tmsel && ((c.ssel == WIT_SRC_SUB && sub_fail) || (c.ssel == WIT_SRC_AUX && aux_fail)))
        begin
            r = WIT_SRC_VLO;
        end
        return r;
    endfunction

    function automatic logic [7:0] ctrl_byte(input wit_ctrl_type c);
        return {c.hold, c.ssel, c.tmsel, 1'b0, c.isel};
    endfunction

    // ***********************************
    // bus decode
    // ***********************************
    logic req;
    logic wr;
    logic rd;
    logic word_acc;
    logic byte_acc;
    logic hit_ctrl;
    logic key_ok;
    logic bad_wr;
    logic good_wr;
    logic cnt_exp;
    logic cnt_tick;
    logic cnt_clr;
    logic puc_evt;
    logic [CNT_W-1:0] cnt_val;

    // one request per cycle; the ack cycle blocks a second capture
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign word_acc = (wb_sel_i[1:0] == 2'h3);
    assign byte_acc = ^wb_sel_i[1:0];
    assign hit_ctrl = (wb_adr_i == WIT_OFS_CTRL);
    assign key_ok = (wb_dat_i[WIT_KEY_LSB +: 8] == WIT_KEY_WR);
    assign bad_wr = wr && hit_ctrl && (byte_acc || (word_acc && !key_ok));
    assign good_wr = wr && hit_ctrl && word_acc && key_ok;
    assign puc_evt = bad_wr || (cnt_exp && !st_ff.ctrl.tmsel);
    assign cnt_clr = (good_wr && wb_dat_i[WIT_CNTCL_BIT]) || puc_evt || other_puc_i;
    assign cnt_tick = clk_tick_i[eff_src(st_ff.ctrl, sub_clk_fail_i, aux_clk_fail_i)];

    // ***********************************
    // counter
    // ***********************************
    // counter has no bus path
    wit_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(cnt_tick),
        .clr_i(cnt_clr),
        .hold_i(st_ff.ctrl.hold),
        .isel_i(st_ff.ctrl.isel),
        .cnt_o(cnt_val),
        .expire_o(cnt_exp)
    );

    // ***********************************
    // next state
    // ***********************************
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.ack = 1'b0;
        nxt_st.power_up_clear_reset = 1'b0;
        if (req)
        begin
            nxt_st.ack = 1'b1;
            nxt_st.dat = 32'h0;
            if (wb_adr_i == WIT_OFS_FLAG)
            begin
                nxt_st.dat[WIT_FLAG_BIT] = st_ff.timer_flag;
            end
            else if (wb_adr_i == WIT_OFS_ENABLE)
            begin
                nxt_st.dat[WIT_FLAG_BIT] = st_ff.timer_irq_enable;
            end
            else if (hit_ctrl && word_acc)
            begin
                nxt_st.dat = {16'h0, WIT_KEY_RD, ctrl_byte(st_ff.ctrl)};
            end
            else if (hit_ctrl && byte_acc)
            begin
                nxt_st.dat = {16'h0, ctrl_byte(st_ff.ctrl), ctrl_byte(st_ff.ctrl)};
            end
        end
        if (wr && wb_adr_i == WIT_OFS_ENABLE && wb_sel_i[0])
        begin
            nxt_st.timer_irq_enable = wb_dat_i[WIT_FLAG_BIT];
        end
        if (wr && wb_adr_i == WIT_OFS_FLAG && wb_sel_i[0])
        begin
            nxt_st.timer_flag = wb_dat_i[WIT_FLAG_BIT];
        end
        if (irq_serviced_i && st_ff.irq)
        begin
            nxt_st.timer_flag = 1'b0;
        end
        if (good_wr)
        begin
            nxt_st.ctrl.hold = wb_dat_i[WIT_HOLD_BIT];
            nxt_st.ctrl.ssel = wb_dat_i[WIT_SSEL_LSB +: 2];
            nxt_st.ctrl.tmsel = wb_dat_i[WIT_TMSEL_BIT];
            nxt_st.ctrl.isel = wb_dat_i[WIT_IS_LSB +: 3];
        end
        // interval expiry sets flag; set wins over clear
        if (cnt_exp && st_ff.ctrl.tmsel)
        begin
            nxt_st.timer_flag = 1'b1;
        end
        // other reset causes leave flag clear
        if (other_puc_i)
        begin
            nxt_st.ctrl = WIT_CTRL_RST;
            nxt_st.timer_flag = 1'b0;
            nxt_st.timer_irq_enable = 1'b0;
        end
        if (puc_evt)
        begin
            nxt_st.ctrl = WIT_CTRL_RST;
            nxt_st.timer_flag = 1'b1;
            nxt_st.timer_irq_enable = 1'b0;
            nxt_st.power_up_clear_reset = 1'b1;
        end
        nxt_st.irq = nxt_st.timer_flag && nxt_st.timer_irq_enable && global_irq_enable_i && nxt_st.ctrl.tmsel;
        // keep the counting clock alive in watchdog mode
        nxt_st.keep = 4'h0;
        if (!nxt_st.ctrl.tmsel)
        begin
            nxt_st.keep = 4'(4'h1 << eff_src(nxt_st.ctrl, sub_clk_fail_i, aux_clk_fail_i));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= WIT_STATE_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign wb_dat_o = st_ff.dat;
    assign wb_ack_o = st_ff.ack;
    assign power_up_clear_reset_o = st_ff.power_up_clear_reset;
    assign interval_irq_o = st_ff.irq;
    assign clk_keep_on_o = st_ff.keep;

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_bad_key;
        wr && hit_ctrl && word_acc && !key_ok |=> power_up_clear_reset_o && st_ff.timer_flag;
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("bad key did not reset");

    property p_read_key;
        rd && hit_ctrl && word_acc |=> wb_ack_o && wb_dat_o[15:8] == WIT_KEY_RD && !wb_dat_o[WIT_CNTCL_BIT];
    endproperty
    a_read_key: assert property (p_read_key) else $error("read key wrong");

    property p_byte_read;
        rd && hit_ctrl && byte_acc
            |=> wb_dat_o[15:8] == wb_dat_o[7:0] && wb_dat_o[7:0] == ctrl_byte($past(st_ff.ctrl));
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("byte read not low byte");

    property p_byte_write;
        wr && hit_ctrl && byte_acc |=> power_up_clear_reset_o ##1 !power_up_clear_reset_o;
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte write did not reset");

    property p_wd_expire;
        cnt_exp && !st_ff.ctrl.tmsel |=> power_up_clear_reset_o && st_ff.ctrl == WIT_CTRL_RST && cnt_val == '0;
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry missed");

    property p_int_expire;
        cnt_exp && st_ff.ctrl.tmsel && !bad_wr && !other_puc_i && !wr
            |=> st_ff.timer_flag && !power_up_clear_reset_o && st_ff.timer_irq_enable == $past(st_ff.timer_irq_enable);
    endproperty
    a_int_expire: assert property (p_int_expire) else $error("interval expiry wrong");

    property p_irq_gate;
        interval_irq_o |-> st_ff.timer_flag && st_ff.timer_irq_enable && $past(global_irq_enable_i) && st_ff.ctrl.tmsel;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without all enables");

    property p_fail_safe;
        !st_ff.ctrl.tmsel && st_ff.ctrl.ssel == WIT_SRC_SUB && sub_clk_fail_i |-> cnt_tick == clk_tick_i[WIT_SRC_VLO];
    endproperty
    a_fail_safe: assert property (p_fail_safe) else $error("no clock fallback");

    property p_hold;
        st_ff.ctrl.hold && !cnt_clr |=> cnt_val == $past(cnt_val) && !cnt_exp;
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while held");

    property p_clear;
        good_wr && wb_dat_i[WIT_CNTCL_BIT] |=> cnt_val == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared");

    property p_start_default;
        power_up_clear_reset_o |-> st_ff.ctrl == WIT_CTRL_RST && clk_keep_on_o == 4'h1 || sub_clk_fail_i;
    endproperty
    a_start_default: assert property (p_start_default) else $error("not default after reset");

    c_wd_reset: cover property (cnt_exp && !st_ff.ctrl.tmsel ##1 power_up_clear_reset_o);
    c_int_irq: cover property (cnt_exp && st_ff.ctrl.tmsel ##1 interval_irq_o);
    c_bad_key: cover property (bad_wr ##1 power_up_clear_reset_o);

endmodule
`default_nettype wire

// [inc/wit_pkg.sv]
// shared constants and types for the watchdog interval timer
package wit_pkg;

    // ***********************************
    // register map and bus
    // ***********************************
    localparam int WIT_ADR_W = 8;
    localparam logic [7:0] WIT_OFS_FLAG = 8'h00;
    localparam logic [7:0] WIT_OFS_ENABLE = 8'h04;
    localparam logic [7:0] WIT_OFS_CTRL = 8'h0C;

    // ***********************************
    // control word fields
    // ***********************************
    localparam logic [7:0] WIT_KEY_WR = 8'h5A;
    localparam logic [7:0] WIT_KEY_RD = 8'h69;
    localparam int WIT_KEY_LSB = 8;
    localparam int WIT_HOLD_BIT = 7;
    localparam int WIT_SSEL_LSB = 5;
    localparam int WIT_TMSEL_BIT = 4;
    localparam int WIT_CNTCL_BIT = 3;
    localparam int WIT_IS_LSB = 0;
    localparam int WIT_FLAG_BIT = 0;

    // ***********************************
    // clock sources
    // ***********************************
    localparam logic [1:0] WIT_SRC_SUB = 2'h0;
    localparam logic [1:0] WIT_SRC_AUX = 2'h1;
    localparam logic [1:0] WIT_SRC_VLO = 2'h2;
    localparam logic [1:0] WIT_SRC_EXT = 2'h3;

    // ***********************************
    // counter and intervals
    // ***********************************
    localparam int WIT_CNT_W = 32;
    // interval is 2**n counts; entry 0 is selection 0
    localparam logic [7:0][4:0] WIT_TAP_BITS = {5'h06, 5'h09, 5'h0D, 5'h0F, 5'h13, 5'h17, 5'h1B, 5'h1F};

    typedef struct packed {
        logic hold;
        logic [1:0] ssel;
        logic tmsel;
        logic [2:0] isel;
    } wit_ctrl_type;

    // selection 4 with the subsystem clock gives the short start-up interval
    localparam wit_ctrl_type WIT_CTRL_RST = '{hold: 1'b0, ssel: 2'h0, tmsel: 1'b0, isel: 3'h4};

endpackage

// [hw/wit_counter.sv]
// 32-bit up counter with selectable expiry interval
`timescale 1ns/1ps
`default_nettype none
module wit_counter
    import wit_pkg::*;
#(
    parameter int CNT_W = WIT_CNT_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic clr_i,
    input wire logic hold_i,
    input wire logic [2:0] isel_i,
    output logic [CNT_W-1:0] cnt_o,
    output logic expire_o
);

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic expire;
    } wit_cnt_state_type;

    wit_cnt_state_type st_ff;
    wit_cnt_state_type nxt_st;
    logic [CNT_W-1:0] low_mask;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.expire = 1'b0;
        low_mask = ~({CNT_W{1'b1}} << WIT_TAP_BITS[isel_i]);
        // clear beats counting so a reload never expires at once
        if (clr_i)
        begin
            nxt_st.cnt = '0;
        end
        else if (tick_i && !hold_i)
        begin
            nxt_st.cnt = st_ff.cnt + CNT_W'(1);
            nxt_st.expire = ((st_ff.cnt & low_mask) == low_mask);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign cnt_o = st_ff.cnt;
    assign expire_o = st_ff.expire;

endmodule
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module tb
    import wit_pkg::*;
;
    typedef struct packed {
        logic p;
        logic c;
        logic [31:0] d;
    } wit_note_type;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] clk_tick_i = 4'h0;
    logic sub_clk_fail_i = 1'b0;
    logic aux_clk_fail_i = 1'b0;
    logic global_irq_enable_i = 1'b0;
    logic irq_serviced_i = 1'b0;
    logic other_puc_i = 1'b0;
    logic power_up_clear_reset_o;
    logic interval_irq_o;
    logic [3:0] clk_keep_on_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] rs = 32'h1E;
    logic [31:0] r;
    wit_note_type notes[$];
    wit_note_type nt;
    int n;

    always #2.5 clk_i = ~clk_i;

    wit_top #(.CNT_W(WIT_CNT_W)) wit_top_i (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .clk_tick_i(clk_tick_i),
        .sub_clk_fail_i(sub_clk_fail_i),
        .aux_clk_fail_i(aux_clk_fail_i),
        .global_irq_enable_i(global_irq_enable_i),
        .irq_serviced_i(irq_serviced_i),
        .other_puc_i(other_puc_i),
        .power_up_clear_reset_o(power_up_clear_reset_o),
        .interval_irq_o(interval_irq_o),
        .clk_keep_on_o(clk_keep_on_o)
    );

    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one classic cycle; the answer is judged by the monitor below
    task automatic bus(input logic [7:0] a, input logic we, input logic [3:0] s, input logic [31:0] d,
                       input logic c, input logic [31:0] e, input logic p);
        int t;
        notes.push_back('{p: p, c: c, d: e});
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_sel_i <= s;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        t = 0;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (wb_ack_o !== 1'b1 && t < 50);
        if (t >= 50)
            check("ack", 32'h0, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
        bus(a, 1'b1, 4'hF, d, 1'b0, 32'h0, p);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 4'hF, 32'h0, 1'b1, e, 1'b0);
    endtask

    // ticks on one lane, noise on the rest; stops at a reset or interrupt
    task automatic run(input int lane, input int lim, output int cnt);
        logic [3:0] m;
        m = 4'h1 << lane;
        cnt = 0;
        do
        begin
            @(posedge clk_i);
            r = xs();
            clk_tick_i <= m | (r[3:0] & ~m);
            cnt++;
        end
        while (power_up_clear_reset_o !== 1'b1 && interval_irq_o !== 1'b1 && cnt < lim);
        clk_tick_i <= 4'h0;
    endtask

    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && notes.size() > 0)
        begin
            nt = notes.pop_front();
            check("reset request", {31'h0, power_up_clear_reset_o}, {31'h0, nt.p});
            if (nt.c)
                check("read data", wb_dat_o, nt.d);
        end
    end

    // ****************
    // main sequence
    // ****************
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(WIT_OFS_CTRL, 32'h6904);
        rd(WIT_OFS_FLAG, 32'h0);
        rd(8'h20, 32'h0);
        bus(WIT_OFS_CTRL, 1'b0, 4'h1, 32'h0, 1'b1, 32'h0404, 1'b0);
        bus(WIT_OFS_CTRL, 1'b0, 4'h2, 32'h0, 1'b1, 32'h0404, 1'b0);
        check("keep on", {28'h0, clk_keep_on_o}, 32'h1);
        $display("test reset done");
        wr(WIT_OFS_CTRL, 32'h5A8F, 1'b0);
        rd(WIT_OFS_CTRL, 32'h6987);
        run(0, 200, n);
        check("held count", n, 200);
        $display("test hold done");
        // steps 4 and 5 stand for a failed aux or subsystem clock, served by the low-power lane
        for (int s = 0; s < 6; s++)
        begin
            aux_clk_fail_i <= (s == 4);
            sub_clk_fail_i <= (s == 5);
            // halt before the source changes
            wr(WIT_OFS_CTRL, 32'h5A8F, 1'b0);
            wr(WIT_OFS_CTRL, 32'h5A0F | (32'((s == 4) ? 1 : (s == 5) ? 0 : s) << 5), 1'b0);
            repeat (2) @(posedge clk_i);
            check("keep on", {28'h0, clk_keep_on_o}, 32'h1 << ((s >= 4) ? 2 : s));
            run((s >= 4) ? 2 : s, 100, n);
            check("expiry cycles", {31'h0, n >= 62 && n <= 68}, 32'h1);
            rd(WIT_OFS_CTRL, 32'h6904);
            rd(WIT_OFS_FLAG, 32'h1);
        end
        aux_clk_fail_i <= 1'b0;
        sub_clk_fail_i <= 1'b0;
        // two longer selections; the rest take too long for a bench run
        for (int i = 5; i < 7; i++)
        begin
            wr(WIT_OFS_CTRL, 32'h5A08 | 32'(i), 1'b0);
            run(0, 9000, n);
            check("long interval", {31'h0, n >= ((i == 5) ? 8192 : 512) && n <= ((i == 5) ? 8198 : 518)}, 32'h1);
        end
        $display("test timeout done");
        @(posedge clk_i);
        other_puc_i <= 1'b1;
        @(posedge clk_i);
        other_puc_i <= 1'b0;
        rd(WIT_OFS_FLAG, 32'h0);
        wr(WIT_OFS_CTRL, 32'h128F, 1'b1);
        rd(WIT_OFS_CTRL, 32'h6904);
        rd(WIT_OFS_FLAG, 32'h1);
        bus(WIT_OFS_CTRL, 1'b1, 4'h1, 32'h5A80, 1'b0, 32'h0, 1'b1);
        rd(WIT_OFS_CTRL, 32'h6904);
        $display("test key done");
        r = xs();
        wr(WIT_OFS_ENABLE, {r[31:1], 1'b1}, 1'b0);
        wr(WIT_OFS_FLAG, 32'h0, 1'b0);
        rd(WIT_OFS_FLAG, 32'h0);
        global_irq_enable_i <= 1'b1;
        wr(WIT_OFS_CTRL, 32'h5A1F, 1'b0);
        repeat (2) @(posedge clk_i);
        check("keep on", {28'h0, clk_keep_on_o}, 32'h0);
        run(0, 100, n);
        check("interval cycles", {31'h0, n >= 62 && n <= 68}, 32'h1);
        check("no reset", {31'h0, power_up_clear_reset_o}, 32'h0);
        rd(WIT_OFS_FLAG, 32'h1);
        rd(WIT_OFS_ENABLE, 32'h1);
        global_irq_enable_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("irq masked", {31'h0, interval_irq_o}, 32'h0);
        global_irq_enable_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("irq", {31'h0, interval_irq_o}, 32'h1);
        irq_serviced_i <= 1'b1;
        @(posedge clk_i);
        irq_serviced_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("irq serviced", {31'h0, interval_irq_o}, 32'h0);
        rd(WIT_OFS_FLAG, 32'h0);
        $display("test interval done");
        end_of_test();
    end

    // whole run is about ten thousand cycles
    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
